//--- rtl/mur_pkg.sv
// Shared constants and types for the modem UART receive status block.
package mur_pkg;

  // Register addresses on the internal register port.
  localparam logic [7:0] EVT_STATUS_ADDR = 8'h80;
  localparam logic [7:0] RX_PORT_ADDR    = 8'h81;
  localparam logic [7:0] FIFO_CTRL_ADDR  = 8'h83;
  localparam logic [7:0] MODEM_CFG_ADDR  = 8'h8a;
  localparam logic [7:0] READ_SEL_ADDR   = 8'h6e;

  // Event status field positions.
  localparam int GAP_BIT     = 0;
  localparam int PAR_BIT     = 1;
  localparam int FRM_BIT     = 2;
  localparam int OVF_BIT     = 3;
  localparam int RXLVL_BIT   = 4;
  localparam int TXLVL_BIT   = 5;
  localparam int TXDONE_BIT  = 6;
  localparam int CDEDGE_BIT  = 7;
  localparam int CD_BIT      = 8;
  localparam int SOM_BIT     = 9;

  // Receive word field positions.
  localparam int RW_BRK_BIT  = 8;
  localparam int RW_PAR_BIT  = 9;
  localparam int RW_FRM_BIT  = 10;
  localparam int RW_GAP_BIT  = 11;

  // FIFO control field positions and reset values.
  localparam int FCR_TX_LSB  = 8;
  localparam int FCR_RX_LSB  = 3;
  localparam int FCR_RFCLR_BIT = 1;
  localparam logic [4:0] TX_THRESH_RST = 5'h08;
  localparam logic [4:0] RX_THRESH_RST = 5'h18;
  localparam logic [7:0] READ_SEL_RST  = 8'h00;
  localparam logic [9:0] STATUS_RST    = 10'h020;

  // Receive FIFO geometry.
  localparam int RX_DEPTH    = 32;
  localparam int RX_AW       = 5;
  localparam int WORD_W      = 12;

  // Link timing: 1200 baud on the link clock.
  localparam int LINK_CLK_PERIOD_NS = 30;
  localparam int BIT_TIME_NS        = 833333;
  localparam int BIT_CYCLES         = BIT_TIME_NS / LINK_CLK_PERIOD_NS;
  localparam int CHAR_BITS          = 11;
  localparam logic [3:0] CHAR_BITS_M1 = 4'ha;

  // Message framing bytes.
  localparam logic [7:0] PREAMBLE_BYTE = 8'hff;
  localparam logic [2:0] DELIM_SHORT   = 3'h2;
  localparam logic [2:0] DELIM_BURST   = 3'h1;
  localparam logic [2:0] DELIM_ACK     = 3'h6;

  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_ANY,
    EDGE_ANY2
  } mur_edge_sel_t;

  typedef struct packed {
    logic       gap;
    logic       frm;
    logic       par;
    logic       brk;
    logic [7:0] data;
  } mur_rx_word_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic        burst;
    logic [15:0] wdata;
  } mur_reg_req_t;

endpackage : mur_pkg

//--- rtl/mur_fifo_mem.sv
// Receive FIFO storage with a registered, write-through read port.
`timescale 1ns/1ps
module mur_fifo_mem
  import mur_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              we_i,
  input  wire logic [RX_AW-1:0]  waddr_i,
  input  wire mur_rx_word_t      wdata_i,
  input  wire logic [RX_AW-1:0]  raddr_i,
  output mur_rx_word_t           rdata_o
);

  mur_rx_word_t mem_r [RX_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // A word written to the address being read shows at once.
  always_ff @(posedge clk_i) begin
    if (we_i && (waddr_i == raddr_i)) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule : mur_fifo_mem

//--- rtl/mur_rx_status.sv
// Modem UART receiver, receive FIFO port and event status register.
`timescale 1ns/1ps
module mur_rx_status
  import mur_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         link_clk_i,
  input  wire logic         rxd_i,
  input  wire logic         carrier_sense_i,
  input  wire logic         tx_byte_sent_i,
  input  wire logic [5:0]   tx_fifo_count_i,
  input  wire mur_reg_req_t reg_req_i,
  output logic [15:0]       reg_rdata_o,
  output logic              reg_rvalid_o,
  output logic              uart_clk_en_o
);

  localparam logic [15:0] BIT_CYC_M1 = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_BIT   = 16'(BIT_CYC / 2);

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP,
    RX_WAIT_HIGH
  } mur_rx_state_t;

  // ---------------- Link clock domain ----------------

  logic          rxd_s1_r;
  logic          rxd_s2_r;
  mur_rx_state_t rx_state_r;
  mur_rx_state_t rx_state_nxt;
  logic [15:0]   bit_cnt_r;
  logic [2:0]    data_idx_r;
  logic [7:0]    shift_r;
  logic          par_err_r;
  logic [3:0]    idle_bits_r;
  logic          seen_char_r;
  logic          gap_pend_r;
  mur_rx_word_t  hold_r;
  logic          char_tgl_r;
  logic          gap_tgl_r;

  wire bit_end   = (bit_cnt_r == BIT_CYC_M1);
  wire mid_bit   = (bit_cnt_r == HALF_BIT);
  wire idle_full = (idle_bits_r == CHAR_BITS_M1) && bit_end && rxd_s2_r;
  wire stop_seen = (rx_state_r == RX_STOP) && mid_bit;
  wire brk_seen  = stop_seen && !rxd_s2_r && (shift_r == 8'h00);

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= rxd_i;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  always_comb begin
    rx_state_nxt = rx_state_r;
    case (rx_state_r)
      RX_IDLE:      if (!rxd_s2_r) rx_state_nxt = RX_START;
      RX_START:     if (mid_bit) rx_state_nxt = rxd_s2_r ? RX_IDLE : RX_DATA;
      RX_DATA:      if (mid_bit && (data_idx_r == 3'h7)) rx_state_nxt = RX_PARITY;
      RX_PARITY:    if (mid_bit) rx_state_nxt = RX_STOP;
      RX_STOP:      if (mid_bit) rx_state_nxt = rxd_s2_r ? RX_IDLE : RX_WAIT_HIGH;
      RX_WAIT_HIGH: if (rxd_s2_r) rx_state_nxt = RX_IDLE;
      default:      rx_state_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_state_r <= RX_IDLE;
      bit_cnt_r  <= 16'h0000;
      data_idx_r <= 3'h0;
      shift_r    <= 8'h00;
      par_err_r  <= 1'b0;
    end else begin
      rx_state_r <= rx_state_nxt;
      if ((rx_state_r == RX_IDLE) ? (!rxd_s2_r || bit_end) : bit_end) begin
        bit_cnt_r <= 16'h0000;
      end else begin
        bit_cnt_r <= bit_cnt_r + 16'h0001;
      end
      if ((rx_state_r == RX_DATA) && mid_bit) begin
        shift_r    <= {rxd_s2_r, shift_r[7:1]};
        data_idx_r <= data_idx_r + 3'h1;
      end else if (rx_state_r == RX_START) begin
        data_idx_r <= 3'h0;
      end
      if ((rx_state_r == RX_PARITY) && mid_bit) begin
        par_err_r <= ~(^{shift_r, rxd_s2_r});
      end
    end
  end

  // Idle time counts in whole bit times; a gap is flagged only once a character has been seen.
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_bits_r <= 4'h0;
      seen_char_r <= 1'b0;
      gap_pend_r  <= 1'b0;
      gap_tgl_r   <= 1'b0;
    end else begin
      if ((rx_state_r != RX_IDLE) || !rxd_s2_r) begin
        idle_bits_r <= 4'h0;
      end else if (bit_end && (idle_bits_r != CHAR_BITS_M1)) begin
        idle_bits_r <= idle_bits_r + 4'h1;
      end
      if (stop_seen) begin
        seen_char_r <= 1'b1;
      end
      if (stop_seen) begin
        gap_pend_r <= 1'b0;
      end else if (idle_full && seen_char_r && !gap_pend_r) begin
        gap_pend_r <= 1'b1;
        gap_tgl_r  <= ~gap_tgl_r;
      end
    end
  end

  // A finished character is held stable for a full character time.
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_r     <= '0;
      char_tgl_r <= 1'b0;
    end else if (stop_seen) begin
      hold_r.gap  <= gap_pend_r;
      hold_r.frm  <= !rxd_s2_r;
      hold_r.par  <= par_err_r;
      hold_r.brk  <= brk_seen;
      hold_r.data <= shift_r;
      char_tgl_r  <= ~char_tgl_r;
    end
  end

  // ---------------- System clock domain ----------------

  logic [2:0]     char_sync_r;
  logic [2:0]     gap_sync_r;
  logic           cd_s1_r;
  logic           cd_s2_r;
  logic           cd_prev_r;
  mur_rx_word_t   new_word_r;
  logic           new_valid_r;
  logic [RX_AW-1:0] wr_ptr_r;
  logic [RX_AW-1:0] rd_ptr_r;
  logic [5:0]     rx_count_r;
  mur_rx_word_t   head_word;
  logic [4:0]     tx_thresh_r;
  logic [4:0]     rx_thresh_r;
  logic           fcr_bit0_r;
  mur_edge_sel_t  edge_sel_r;
  logic [7:0]     read_sel_r;
  logic [7:0]     burst_addr_r;
  logic [1:0]     pre_cnt_r;
  logic [9:0]     status_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      char_sync_r <= 3'h0;
      gap_sync_r  <= 3'h0;
      cd_s1_r     <= 1'b0;
      cd_s2_r     <= 1'b0;
      cd_prev_r   <= 1'b0;
    end else begin
      char_sync_r <= {char_sync_r[1:0], char_tgl_r};
      gap_sync_r  <= {gap_sync_r[1:0], gap_tgl_r};
      cd_s1_r     <= carrier_sense_i;
      cd_s2_r     <= cd_s1_r;
      cd_prev_r   <= cd_s2_r;
    end
  end

  wire char_evt = char_sync_r[2] ^ char_sync_r[1];
  wire gap_evt  = gap_sync_r[2] ^ gap_sync_r[1];

  // The held word is stable here because the toggle crossed after it settled.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      new_word_r  <= '0;
      new_valid_r <= 1'b0;
    end else begin
      new_valid_r <= char_evt;
      if (char_evt) begin
        new_word_r <= hold_r;
      end
    end
  end

  // Register port decode.
  wire [7:0] eff_addr  = reg_req_i.burst ? burst_addr_r : reg_req_i.addr;
  wire       rd_rx     = reg_req_i.rd && (eff_addr == RX_PORT_ADDR);
  wire       rx_empty  = (rx_count_r == 6'h00);
  wire       rx_full   = (rx_count_r == 6'(RX_DEPTH));
  wire       pop       = rd_rx && !rx_empty;
  wire       push      = new_valid_r && !rx_full;
  wire       wr_status = reg_req_i.wr && (reg_req_i.addr == EVT_STATUS_ADDR);
  wire       wr_fcr    = reg_req_i.wr && (reg_req_i.addr == FIFO_CTRL_ADDR);
  wire       rx_clear  = wr_fcr && reg_req_i.wdata[FCR_RFCLR_BIT];

  mur_fifo_mem u_fifo_mem (
    .clk_i   (clk_i),
    .we_i    (push),
    .waddr_i (wr_ptr_r),
    .wdata_i (new_word_r),
    .raddr_i (rx_clear ? '0 : (rd_ptr_r + RX_AW'(pop))),
    .rdata_o (head_word)
  );

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      rx_count_r <= 6'h00;
    end else if (rx_clear) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      rx_count_r <= 6'h00;
    end else begin
      wr_ptr_r   <= wr_ptr_r + RX_AW'(push);
      rd_ptr_r   <= rd_ptr_r + RX_AW'(pop);
      rx_count_r <= rx_count_r + 6'(push) - 6'(pop);
    end
  end

  // Configuration registers.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_thresh_r <= TX_THRESH_RST;
      rx_thresh_r <= RX_THRESH_RST;
      fcr_bit0_r  <= 1'b1;
      edge_sel_r  <= EDGE_RISE;
      read_sel_r  <= READ_SEL_RST;
      uart_clk_en_o <= 1'b0;
    end else begin
      if (wr_fcr) begin
        tx_thresh_r <= reg_req_i.wdata[FCR_TX_LSB +: 5];
        rx_thresh_r <= reg_req_i.wdata[FCR_RX_LSB +: 5];
        fcr_bit0_r  <= reg_req_i.wdata[0];
      end
      if (reg_req_i.wr && (reg_req_i.addr == MODEM_CFG_ADDR)) begin
        edge_sel_r <= mur_edge_sel_t'(reg_req_i.wdata[1:0]);
      end
      if (reg_req_i.wr && (reg_req_i.addr == READ_SEL_ADDR)) begin
        read_sel_r    <= reg_req_i.wdata[7:0];
        uart_clk_en_o <= (reg_req_i.wdata[7:0] == RX_PORT_ADDR);
      end
    end
  end

  // Burst reads step the address except at the receive port.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      burst_addr_r <= 8'h00;
    end else if (reg_req_i.rd) begin
      burst_addr_r <= rd_rx ? RX_PORT_ADDR : eff_addr + 8'h01;
    end
  end

  // Start of message watch on the incoming byte stream.
  function automatic logic is_delim(input logic [7:0] b);
    is_delim = (b[2:0] == DELIM_SHORT) || (b[2:0] == DELIM_BURST) || (b[2:0] == DELIM_ACK);
  endfunction : is_delim

  wire nw_err  = new_word_r.frm || new_word_r.par || new_word_r.brk || new_word_r.gap;
  wire som_hit = new_valid_r && !nw_err && (pre_cnt_r == 2'h2) && is_delim(new_word_r.data);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_cnt_r <= 2'h0;
    end else if (new_valid_r) begin
      if (!nw_err && (new_word_r.data == PREAMBLE_BYTE)) begin
        pre_cnt_r <= (pre_cnt_r == 2'h2) ? 2'h2 : pre_cnt_r + 2'h1;
      end else begin
        pre_cnt_r <= 2'h0;
      end
    end
  end

  // Status flags: for the sticky flags a set in the same cycle as its clear wins; CD, TXLVL and RXLVL follow their sources.
  wire rise_e = cd_s2_r && !cd_prev_r;
  wire fall_e = !cd_s2_r && cd_prev_r;
  wire edge_hit = (edge_sel_r == EDGE_RISE) ? rise_e :
                  (edge_sel_r == EDGE_FALL) ? fall_e : (rise_e || fall_e);
  wire [9:0] clr_mask = wr_status ? reg_req_i.wdata[9:0] : 10'h000;
  logic [9:0] sticky_set;
  logic [9:0] status_nxt;

  always_comb begin
    sticky_set             = 10'h000;
    sticky_set[SOM_BIT]    = som_hit;
    sticky_set[CDEDGE_BIT] = edge_hit;
    sticky_set[TXDONE_BIT] = tx_byte_sent_i && (tx_fifo_count_i == 6'h00);
    sticky_set[OVF_BIT]    = new_valid_r && rx_full;
    sticky_set[FRM_BIT]    = new_valid_r && new_word_r.frm;
    sticky_set[PAR_BIT]    = new_valid_r && new_word_r.par;
    sticky_set[GAP_BIT]    = gap_evt;
    status_nxt = (status_r & ~clr_mask) | sticky_set;
    status_nxt[CD_BIT]    = cd_s2_r;
    status_nxt[TXLVL_BIT] = ({1'b0, tx_fifo_count_i} <= {2'b00, tx_thresh_r});
    status_nxt[RXLVL_BIT] = ({1'b0, rx_count_r} >= {2'b00, rx_thresh_r});
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_r <= STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Read data path.
  wire [15:0] rx_word = rx_empty ? 16'h0000 : {4'h0, head_word.gap, head_word.frm,
                                              head_word.par, head_word.brk, head_word.data};
  wire [15:0] fcr_word = {3'h0, tx_thresh_r, rx_thresh_r, 2'h0, fcr_bit0_r};
  logic [15:0] rd_mux;

  always_comb begin
    case (eff_addr)
      EVT_STATUS_ADDR: rd_mux = {6'h00, status_r};
      RX_PORT_ADDR:    rd_mux = rx_word;
      FIFO_CTRL_ADDR:  rd_mux = fcr_word;
      MODEM_CFG_ADDR:  rd_mux = {14'h0000, edge_sel_r};
      READ_SEL_ADDR:   rd_mux = {8'h00, read_sel_r};
      default:         rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

endmodule : mur_rx_status

//--- dv/mur_link_model.sv
// Behavioural UART transmitter that drives the receive line of the block.
`timescale 1ns/1ps
module mur_link_model #(
  parameter int BC = 16
) (
  input  wire logic link_clk_i,
  output logic      rxd_o
);
  initial rxd_o = 1'b1;

  // Sends start, eight data bits LSB first, odd parity and stop; a break holds the line low.
  task automatic send(input logic [7:0] b, input logic bad_par, input logic brk);
    logic [10:0] f;
    f = brk ? 11'h000 : {1'b1, ~^b ^ bad_par, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge link_clk_i);
      rxd_o <= f[i];
      repeat (BC - 1) @(posedge link_clk_i);
    end
    @(posedge link_clk_i);
    rxd_o <= 1'b1;
    if (brk) begin
      repeat (2 * BC) @(posedge link_clk_i);
    end
  endtask : send

  task automatic idle(input int bits);
    repeat (bits * BC) @(posedge link_clk_i);
  endtask : idle
endmodule : mur_link_model

//--- dv/mur_rx_status_chk.sv
// Port-level assertions for the modem UART receive status block.
`timescale 1ns/1ps
module mur_rx_status_chk
  import mur_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_b_i,
  input wire logic         carrier_sense_i,
  input wire mur_reg_req_t reg_req_i,
  input wire logic [15:0]  reg_rdata_o,
  input wire logic         reg_rvalid_o,
  input wire logic         uart_clk_en_o
);
  logic       cs_q;
  logic [2:0] cs_cnt;
  wire        rd1    = reg_req_i.rd && !reg_req_i.burst;
  wire        sel_wr = reg_req_i.wr && reg_req_i.addr == READ_SEL_ADDR;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // Counts edges over which carrier sense held still, so the synchroniser has settled.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_q   <= 1'b0;
      cs_cnt <= 3'h0;
    end else begin
      cs_q   <= carrier_sense_i;
      cs_cnt <= (cs_q != carrier_sense_i) ? 3'h0 : (cs_cnt == 3'h7) ? cs_cnt : cs_cnt + 3'h1;
    end
  end

  rd_answer_a: assert property (reg_req_i.rd |=> reg_rvalid_o)
    else $error("read not answered one cycle later");
  no_spurious_a: assert property (reg_rvalid_o |-> $past(reg_req_i.rd))
    else $error("read answer without a read");
  data_hold_a: assert property (!reg_req_i.rd |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  clk_en_set_a: assert property (
    sel_wr && reg_req_i.wdata[7:0] == RX_PORT_ADDR |=> uart_clk_en_o)
    else $error("uart clock not enabled");
  clk_en_clr_a: assert property (
    sel_wr && reg_req_i.wdata[7:0] != RX_PORT_ADDR |=> !uart_clk_en_o)
    else $error("uart clock not gated off");
  en_hold_a: assert property (!sel_wr |=> $stable(uart_clk_en_o))
    else $error("uart clock enable moved on its own");
  rx_resv_a: assert property (
    rd1 && reg_req_i.addr == RX_PORT_ADDR |=> reg_rdata_o[15:12] == 4'h0)
    else $error("receive word upper bits not zero");
  unmapped_zero_a: assert property (
    rd1 && reg_req_i.addr == 8'h10 |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  carrier_live_a: assert property (
    rd1 && reg_req_i.addr == EVT_STATUS_ADDR && cs_cnt > 3'h4
    |=> reg_rdata_o[CD_BIT] == $past(carrier_sense_i))
    else $error("carrier status not live");
endmodule : mur_rx_status_chk

//--- dv/mur_rx_status_tb.sv
// Self-checking testbench for the modem UART receive status block.
`timescale 1ns/1ps
module mur_rx_status_tb
  import mur_pkg::*;
;
  localparam int BC = 16;
  logic         clk_i, rst_b_i, link_clk_i, rxd, carrier_sense_i, tx_byte_sent_i;
  logic [5:0]   tx_fifo_count_i;
  mur_reg_req_t req;
  logic [15:0]  rdata;
  logic         rvalid, clk_en;
  int           n_mismatch, comparisons;
  logic [15:0]  got [0:35];

  mur_rx_status #(.BIT_CYC(BC)) u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i), .rxd_i(rxd),
    .carrier_sense_i(carrier_sense_i), .tx_byte_sent_i(tx_byte_sent_i),
    .tx_fifo_count_i(tx_fifo_count_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .uart_clk_en_o(clk_en));
  mur_link_model #(.BC(BC)) u_link (.link_clk_i(link_clk_i), .rxd_o(rxd));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7.3;
    forever #15 link_clk_i = ~link_clk_i;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    #1;
    req = '{addr: a, rd: 1'b0, wr: 1'b1, burst: 1'b0, wdata: v};
    @(posedge clk_i);
    #1;
    req.wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_i);
    #1;
    req = '{addr: a, rd: 1'b1, wr: 1'b0, burst: 1'b0, wdata: 16'h0000};
    @(posedge clk_i);
    #1;
    chk({15'h0, rvalid}, 16'h0001);
    chk(rdata & m, e);
    req.rd = 1'b0;
  endtask : rd_chk

  // Continuation words carry a foreign address to show the port address is held.
  task automatic rd_burst(input int n);
    @(posedge clk_i);
    #1;
    req = '{addr: RX_PORT_ADDR, rd: 1'b1, wr: 1'b0, burst: 1'b0, wdata: 16'h0000};
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      #1;
      got[i] = rdata;
      chk({15'h0, rvalid}, 16'h0001);
      req.burst = 1'b1;
      req.addr = 8'h10;
      req.rd = (i < n - 1);
    end
  endtask : rd_burst

  task automatic cd(input logic v, input logic e);
    @(posedge clk_i);
    #1;
    carrier_sense_i = v;
    repeat (6) @(posedge clk_i);
    rd_chk(EVT_STATUS_ADDR, 16'h0180, {7'h0, v, e, 7'h0});
    wr(EVT_STATUS_ADDR, 16'h0080);
  endtask : cd

  task automatic txp(input logic [5:0] c, input logic e6, input logic e5);
    @(posedge clk_i);
    #1;
    tx_fifo_count_i = c;
    tx_byte_sent_i = 1'b1;
    @(posedge clk_i);
    #1;
    tx_byte_sent_i = 1'b0;
    repeat (4) @(posedge clk_i);
    rd_chk(EVT_STATUS_ADDR, 16'h0060, {9'h0, e6, e5, 5'h0});
    wr(EVT_STATUS_ADDR, 16'h0040);
  endtask : txp

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #500_000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    rst_b_i = 1'b0;
    carrier_sense_i = 1'b0;
    tx_byte_sent_i = 1'b0;
    tx_fifo_count_i = 6'h00;
    req = '0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    rd_chk(EVT_STATUS_ADDR, 16'hffff, 16'h0020);
    rd_chk(RX_PORT_ADDR, 16'hffff, 16'h0000);
    rd_chk(FIFO_CTRL_ADDR, 16'hffff, 16'h08c1);
    rd_chk(8'h10, 16'hffff, 16'h0000);
    chk({15'h0, clk_en}, 16'h0000);
    wr(READ_SEL_ADDR, {8'h00, RX_PORT_ADDR});
    chk({15'h0, clk_en}, 16'h0001);
    rd_chk(READ_SEL_ADDR, 16'hffff, {8'h00, RX_PORT_ADDR});
    wr(FIFO_CTRL_ADDR, 16'h0819);
    $display("test reset done");
    u_link.send(8'hff, 1'b0, 1'b0);
    u_link.send(8'hff, 1'b0, 1'b0);
    u_link.send(8'h02, 1'b0, 1'b0);
    repeat (20) @(posedge clk_i);
    rd_chk(EVT_STATUS_ADDR, 16'h0210, 16'h0210);
    rd_burst(3);
    chk(got[0], 16'h00ff);
    chk(got[1], 16'h00ff);
    chk(got[2], 16'h0002);
    rd_chk(EVT_STATUS_ADDR, 16'h0010, 16'h0000);
    wr(EVT_STATUS_ADDR, 16'h0200);
    rd_chk(EVT_STATUS_ADDR, 16'h0200, 16'h0000);
    $display("test message start done");
    u_link.idle(12);
    u_link.send(8'h55, 1'b1, 1'b0);
    u_link.send(8'h00, 1'b0, 1'b1);
    u_link.send(8'h3c, 1'b0, 1'b0);
    repeat (20) @(posedge clk_i);
    rd_chk(EVT_STATUS_ADDR, 16'h0007, 16'h0007);
    rd_burst(3);
    chk(got[0], 16'h0a55);
    chk(got[1] & 16'hfdff, 16'h0500);
    chk(got[2], 16'h003c);
    wr(EVT_STATUS_ADDR, 16'h0007);
    rd_chk(EVT_STATUS_ADDR, 16'h0007, 16'h0000);
    $display("test receive faults done");
    for (int s = 0; s < 4; s++) begin
      wr(MODEM_CFG_ADDR, 16'(s));
      cd(1'b1, s != 1);
      cd(1'b0, s != 0);
    end
    $display("test carrier done");
    txp(6'h03, 1'b0, 1'b1);
    txp(6'h09, 1'b0, 1'b0);
    txp(6'h08, 1'b0, 1'b1);
    txp(6'h00, 1'b1, 1'b1);
    $display("test transmit flags done");
    for (int i = 0; i < 33; i++) begin
      u_link.send(8'(i), 1'b0, 1'b0);
    end
    repeat (20) @(posedge clk_i);
    rd_chk(EVT_STATUS_ADDR, 16'h0018, 16'h0018);
    rd_burst(32);
    for (int i = 0; i < 32; i++) begin
      chk(got[i] & 16'h00ff, 16'(i));
    end
    rd_chk(RX_PORT_ADDR, 16'hffff, 16'h0000);
    wr(EVT_STATUS_ADDR, 16'h0008);
    rd_chk(EVT_STATUS_ADDR, 16'h0008, 16'h0000);
    u_link.send(8'h11, 1'b0, 1'b0);
    u_link.send(8'h22, 1'b0, 1'b0);
    u_link.send(8'h33, 1'b0, 1'b0);
    repeat (20) @(posedge clk_i);
    rd_chk(EVT_STATUS_ADDR, 16'h0010, 16'h0010);
    wr(FIFO_CTRL_ADDR, 16'h081b);
    rd_chk(EVT_STATUS_ADDR, 16'h0010, 16'h0000);
    rd_chk(RX_PORT_ADDR, 16'hffff, 16'h0000);
    wr(READ_SEL_ADDR, 16'h0000);
    chk({15'h0, clk_en}, 16'h0000);
    $display("test overrun done");
    tally_and_finish();
  end
endmodule : mur_rx_status_tb

bind mur_rx_status mur_rx_status_chk u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .carrier_sense_i(carrier_sense_i),
  .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .uart_clk_en_o(uart_clk_en_o));
